// *** core/fbo_core.sv ***
// Frame buffer overflow supervisor: gates the camera stream into the
// frame buffer by fill level and reports each frame's fate as an event.
// Assumes camera stream, fill level and buffer write port share hclk;
// the buffer write port always accepts; one AHB-Lite slave select.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fbo_defs.svh"

// How it works
// [R01] Sync overflow entered above threshold only at a frame boundary.
// [R02] While sync overflow holds, newly starting frames are dropped whole.
// [R03] Sync overflow leaves once fill falls below the same threshold.
// [R04] Sync threshold read/write, half-percent steps 0..200, reset 80.0 %.
// [R05] Truncated filter: one event per truncated frame.
// [R06] Dropped filter: one event per dropped frame.
// [R07] Default filter: event per truncated or dropped frame.
// [R08] Good filter: event per correctly transferred frame.
// [R09] Truncated-or-good filter: event for truncated or complete frames.
// [R10] Dropped-or-good filter: event for dropped or complete frames.
// [R11] All filter: event for every frame with its status.
// [R12] 64-bit event word, frame number in bits 15..0.
// [R13] Overflow mask occupies bits 47..32 of the event word.
// [R14] Frame number is the camera's 16-bit number, wrapping naturally.
// [R15] Truncated frame is still written, shortened, closed by an empty beat.
// [R16] Dropped frame writes nothing to the buffer.
// [R17] Truncated and dropped never set in the same event.
// [R18] Event exposes frame number and truncated, dropped, complete flags.
// [R19] Fill level readable as integer percent 0..100.
// [R20] Above immediate stop threshold the current frame stops at once.
// [R21] Immediate state ends below resume threshold; frames meanwhile dropped.
// [R22] Sticky overflow flag reads 1 after overflow, clears on read.
// [R23] Mask bit 32 truncated, 33 dropped, 34 complete, rest zero.
// [R24] Timestamp in bits 31..16 and 63..48; events queued in order, lossless.
module fbo_core #(
    parameter int EQ_DEPTH = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Camera stream and buffer fill level
    input wire fbo_pkg::fbo_cam_beat_t cam_in,
    output logic cam_ready,
    input wire logic [6:0] fill_level,
    // Buffer write port
    output fbo_pkg::fbo_buf_beat_t buf_out,
    // Event channel
    output logic ev_valid,
    output logic [63:0] ev_word,
    input wire logic ev_ready
);
    import fbo_pkg::*;

    localparam int CW = $clog2(EQ_DEPTH + 1);
    localparam int PW = (EQ_DEPTH > 1) ? $clog2(EQ_DEPTH) : 1;

    // Queue must hold at least one event beyond the ready margin
    if (EQ_DEPTH < 2 || (EQ_DEPTH & (EQ_DEPTH - 1)) != 0) begin : g_depth_check
        $error("EQ_DEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] sync_drop_threshold_r;
    logic [7:0] immediate_stop_threshold_r;
    logic [7:0] resume_threshold_r;
    fbo_filter_t frame_event_filter_r;
    logic [6:0] fill_r;
    logic sticky_r;
    logic imm_ovf_r;
    logic sync_ovf_r;
    logic in_frame_r;
    logic drop_r;
    logic trunc_r;
    logic [31:0] ts_r;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    fbo_buf_beat_t buf_r;
    logic cam_ready_r;
    logic ev_valid_r;
    logic [63:0] ev_word_r;
    logic [63:0] eq_mem [EQ_DEPTH];
    logic [PW-1:0] eq_wp_r;
    logic [PW-1:0] eq_rp_r;
    logic [CW-1:0] eq_cnt_r;
    logic [31:0] hrdata_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Zero wait states: every address phase is taken as soon as it is seen
    wire ahb_go = hsel && hready && htrans[1];
    wire ahb_rd = ahb_go && !hwrite;
    wire ahb_wr = ahb_go && hwrite;
    wire rd_status = ahb_rd && (haddr == `FBO_OFS_STATUS);
    wire wr_sync = wr_pend_r && (wr_addr_r == `FBO_OFS_SYNC_THR);
    wire wr_stop = wr_pend_r && (wr_addr_r == `FBO_OFS_STOP_THR);
    wire wr_resume = wr_pend_r && (wr_addr_r == `FBO_OFS_RESUME_THR);
    wire wr_filter = wr_pend_r && (wr_addr_r == `FBO_OFS_FILTER);
    // Out-of-range threshold writes clamp to 100.0 % rather than wrap
    wire [7:0] thr_wdata = (hwdata[31:8] != 24'h000000 || hwdata[7:0] > `FBO_THR_MAX) ?
                           `FBO_THR_MAX : hwdata[7:0];
    // Unused encoding 7 is ignored so the filter always stays legal
    wire filter_ok = hwdata[31:3] == 29'h00000000 && hwdata[2:0] != 3'h7;

    // Read mux; unmapped offsets read zero
    wire [31:0] rd_mux =
        (haddr == `FBO_OFS_SYNC_THR) ? {24'h000000, sync_drop_threshold_r} :
        (haddr == `FBO_OFS_STOP_THR) ? {24'h000000, immediate_stop_threshold_r} :
        (haddr == `FBO_OFS_RESUME_THR) ? {24'h000000, resume_threshold_r} :
        (haddr == `FBO_OFS_FILTER) ? {29'h00000000, frame_event_filter_r} :
        (haddr == `FBO_OFS_FILL) ? {25'h0000000, fill_r} :
        (haddr == `FBO_OFS_STATUS) ? {29'h00000000, sync_ovf_r, imm_ovf_r, sticky_r} :
        32'h00000000;

    // ------------------------------------------------------------------
    // Overflow states
    // ------------------------------------------------------------------
    // Fill level doubled to compare against half-percent thresholds
    wire [7:0] fill2 = {fill_r, 1'b0};
    wire acc = cam_in.valid && cam_ready_r;
    wire frame_end = acc && cam_in.eof;
    wire in_frame_nxt = acc ? (!cam_in.eof && (cam_in.sof || in_frame_r)) : in_frame_r;
    wire imm_ovf_nxt = (fill2 > immediate_stop_threshold_r) ? 1'b1 :  // R20
                       (fill2 < resume_threshold_r) ? 1'b0 : imm_ovf_r;  // R21
    // Entry waits until the arriving frame is fully stored
    wire sync_ovf_nxt = (fill2 < sync_drop_threshold_r) ? 1'b0 :  // R03
                        (fill2 > sync_drop_threshold_r && !in_frame_nxt) ? 1'b1 :  // R01
                        sync_ovf_r;

    // ------------------------------------------------------------------
    // Frame fate
    // ------------------------------------------------------------------
    // A frame starting during either overflow state is dropped whole
    wire cur_drop = cam_in.sof ? (sync_ovf_r || imm_ovf_r) : drop_r;  // R02 R21
    // Immediate overflow cuts a running frame; drop takes priority
    wire cur_trunc = !cur_drop && ((!cam_in.sof && trunc_r) || imm_ovf_r);  // R20 R17
    wire cur_good = !cur_drop && !cur_trunc;
    wire fwd = acc && cur_good;  // R16
    wire close_trunc = frame_end && cur_trunc;  // R15

    fbo_buf_beat_t buf_nxt;
    assign buf_nxt.valid = fwd || close_trunc;
    assign buf_nxt.sof = cam_in.sof && fwd;
    assign buf_nxt.eof = cam_in.eof;
    assign buf_nxt.empty = close_trunc;
    assign buf_nxt.truncated = close_trunc;
    assign buf_nxt.data = fwd ? cam_in.data : 32'h00000000;

    // ------------------------------------------------------------------
    // Event filter and word
    // ------------------------------------------------------------------
    logic ev_match;
    always_comb begin
        case (frame_event_filter_r)
            FBO_EV_TRUNCATED: ev_match = cur_trunc;  // R05
            FBO_EV_DROPPED: ev_match = cur_drop;  // R06
            FBO_EV_TRUNCATED_OR_DROPPED: ev_match = cur_trunc || cur_drop;  // R07
            FBO_EV_GOOD: ev_match = cur_good;  // R08
            FBO_EV_TRUNCATED_OR_GOOD: ev_match = cur_trunc || cur_good;  // R09
            FBO_EV_DROPPED_OR_GOOD: ev_match = cur_drop || cur_good;  // R10
            FBO_EV_ALL: ev_match = 1'b1;  // R11
            default: ev_match = 1'b0;
        endcase
    end

    fbo_event_t ev_new;
    assign ev_new.frame_no = cam_in.frame_no;  // R12 R14 R18
    assign ev_new.ts_lo = ts_r[15:0];  // R24
    assign ev_new.truncated = cur_trunc;  // R13 R23
    assign ev_new.dropped = cur_drop;  // R23
    assign ev_new.good = cur_good;  // R23 R18
    assign ev_new.mask_rsvd = 13'h0000;
    assign ev_new.ts_hi = ts_r[31:16];  // R24

    // ------------------------------------------------------------------
    // Event queue
    // ------------------------------------------------------------------
    wire eq_push = frame_end && ev_match;
    wire eq_pop = (eq_cnt_r != '0) && (!ev_valid_r || ev_ready);
    wire [CW-1:0] eq_cnt_nxt = CW'(eq_cnt_r + CW'(eq_push) - CW'(eq_pop));
    // Ready is registered, so keep one free slot for the beat in flight
    wire cam_ready_nxt = eq_cnt_nxt <= CW'(EQ_DEPTH - 2);  // R24

    // Queue storage, written in frame order
    always_ff @(posedge hclk) begin
        if (eq_push) begin
            eq_mem[eq_wp_r] <= ev_new;  // R24
        end
    end

    // Queue pointers and output register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eq_wp_r <= '0;
            eq_rp_r <= '0;
            eq_cnt_r <= '0;
            ev_valid_r <= 1'b0;
            ev_word_r <= 64'h0000000000000000;
            cam_ready_r <= 1'b0;
        end else begin
            eq_wp_r <= eq_push ? PW'(eq_wp_r + 1'b1) : eq_wp_r;
            eq_rp_r <= eq_pop ? PW'(eq_rp_r + 1'b1) : eq_rp_r;
            eq_cnt_r <= eq_cnt_nxt;
            if (eq_pop) begin
                ev_valid_r <= 1'b1;
                ev_word_r <= eq_mem[eq_rp_r];
            end else if (ev_ready) begin
                ev_valid_r <= 1'b0;
            end
            cam_ready_r <= cam_ready_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Frame tracking, overflow states, timestamp
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_frame_r <= 1'b0;
            drop_r <= 1'b0;
            trunc_r <= 1'b0;
            imm_ovf_r <= 1'b0;
            sync_ovf_r <= 1'b0;
            fill_r <= 7'h00;
            ts_r <= 32'h00000000;
            buf_r <= '0;
        end else begin
            in_frame_r <= in_frame_nxt;
            if (acc) begin
                drop_r <= cur_drop;
                trunc_r <= cur_trunc;
            end
            imm_ovf_r <= imm_ovf_nxt;
            sync_ovf_r <= sync_ovf_nxt;
            // Readings above full are held at 100 %
            fill_r <= (fill_level > `FBO_FILL_MAX) ? `FBO_FILL_MAX : fill_level;  // R19
            ts_r <= ts_r + 32'h00000001;
            buf_r <= buf_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register file and bus answer
    // ------------------------------------------------------------------
    // Sticky flag: a new overflow in the read cycle survives the clear
    wire sticky_set = frame_end && !cur_good;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_drop_threshold_r <= `FBO_SYNC_THR_RST;
            immediate_stop_threshold_r <= `FBO_STOP_THR_RST;
            resume_threshold_r <= `FBO_RESUME_THR_RST;
            frame_event_filter_r <= fbo_filter_t'(`FBO_FILTER_RST);
            sticky_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= ahb_wr;
            wr_addr_r <= ahb_wr ? haddr : wr_addr_r;
            hrdata_r <= ahb_rd ? rd_mux : 32'h00000000;
            if (wr_sync) begin
                sync_drop_threshold_r <= thr_wdata;  // R04
            end
            if (wr_stop) begin
                immediate_stop_threshold_r <= thr_wdata;
            end
            if (wr_resume) begin
                resume_threshold_r <= thr_wdata;
            end
            if (wr_filter && filter_ok) begin
                frame_event_filter_r <= fbo_filter_t'(hwdata[2:0]);
            end
            sticky_r <= sticky_set || (sticky_r && !rd_status);  // R22
        end
    end

    // Outputs straight from flip-flops, except hreadyout and hresp, which are constants
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign cam_ready = cam_ready_r;
    assign buf_out = buf_r;
    assign ev_valid = ev_valid_r;
    assign ev_word = ev_word_r;

endmodule // fbo_core

// *** core/fbo_defs.svh ***
// Constants for the frame buffer overflow supervisor: register offsets,
// reset values, field positions and full-scale limits.
// Assumes inclusion by the core module only.
`ifndef FBO_DEFS_SVH
`define FBO_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FBO_OFS_SYNC_THR 12'h000
`define FBO_OFS_STOP_THR 12'h004
`define FBO_OFS_RESUME_THR 12'h008
`define FBO_OFS_FILTER 12'h00C
`define FBO_OFS_FILL 12'h010
`define FBO_OFS_STATUS 12'h014

// ----------------------------------------------------------------------
// Thresholds in half-percent steps (0..200 stands for 0.0..100.0 %), fill limit in whole percent, filter reset
// ----------------------------------------------------------------------
`define FBO_THR_MAX 8'hC8
`define FBO_SYNC_THR_RST 8'hA0
`define FBO_STOP_THR_RST 8'hC7
`define FBO_RESUME_THR_RST 8'h64
`define FBO_FILL_MAX 7'h64
`define FBO_FILTER_RST 3'h2

// ----------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------
`define FBO_ST_STICKY 0
`define FBO_ST_IMM 1
`define FBO_ST_SYNC 2

// ----------------------------------------------------------------------
// Event word layout
// ----------------------------------------------------------------------
`define FBO_EV_TRUNC_BIT 32
`define FBO_EV_DROP_BIT 33
`define FBO_EV_GOOD_BIT 34

`endif

// *** core/fbo_pkg.sv ***
// Types shared by the overflow supervisor and its bench.
// Assumes fbo_defs.svh holds the numeric constants.
package fbo_pkg;

    // ------------------------------------------------------------------
    // Event filter settings, in register encoding order
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FBO_EV_TRUNCATED,
        FBO_EV_DROPPED,
        FBO_EV_TRUNCATED_OR_DROPPED,
        FBO_EV_GOOD,
        FBO_EV_TRUNCATED_OR_GOOD,
        FBO_EV_DROPPED_OR_GOOD,
        FBO_EV_ALL
    } fbo_filter_t;

    // ------------------------------------------------------------------
    // Camera beat in, buffer write beat out, event word out
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [15:0] frame_no;
        logic [31:0] data;
    } fbo_cam_beat_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic empty;     // Closing beat of a truncated frame, no data
        logic truncated;
        logic [31:0] data;
    } fbo_buf_beat_t;

    typedef struct packed {
        logic [15:0] ts_hi;
        logic [12:0] mask_rsvd;
        logic good;
        logic dropped;
        logic truncated;
        logic [15:0] ts_lo;
        logic [15:0] frame_no;
    } fbo_event_t;

endpackage

// *** tb/fbo_core_assertions.sv ***
// Port-level checks for the frame buffer overflow supervisor.
// Assumes it is bound to fbo_core and sees only that module's ports.
`timescale 1ns/1ps
module fbo_core_checker #(
    parameter int EQ_DEPTH = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Stream, buffer and events
    input wire fbo_pkg::fbo_cam_beat_t cam_in,
    input wire logic cam_ready,
    input wire logic [6:0] fill_level,
    input wire fbo_pkg::fbo_buf_beat_t buf_out,
    input wire logic ev_valid,
    input wire logic [63:0] ev_word,
    input wire logic ev_ready
);
    import fbo_pkg::*;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A read request taken at an edge, answered one cycle later
    logic rd_c;
    assign rd_c = hsel && hready && htrans[1] && !hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    thr_range_a: assert property ($past(rd_c && haddr < 12'h00C) |-> hrdata <= 32'hC8)
        else $error("threshold read above full scale");
    fill_range_a: assert property ($past(rd_c && haddr == 12'h010) |-> hrdata <= 32'h64)
        else $error("fill read above one hundred");
    flag_excl_a: assert property (ev_valid |-> !(ev_word[32] && ev_word[33]))
        else $error("event both truncated and dropped");
    mask_rsvd_a: assert property (ev_valid |-> ev_word[47:35] == 13'h0 && $onehot(ev_word[34:32]))
        else $error("event mask malformed");
    event_hold_a: assert property (ev_valid && !ev_ready |=> ev_valid && $stable(ev_word))
        else $error("stalled event changed or vanished");
    trunc_close_a: assert property (buf_out.valid && buf_out.empty |->
        buf_out.eof && buf_out.truncated && buf_out.data == 32'h0)
        else $error("empty beat not a truncated close");
    write_src_a: assert property (buf_out.valid |-> $past(cam_in.valid && cam_ready))
        else $error("buffer write without camera beat");
    sof_src_a: assert property (buf_out.valid && buf_out.sof |-> $past(cam_in.sof))
        else $error("frame start written mid-frame");
endmodule // fbo_core_checker

bind fbo_core fbo_core_checker #(.EQ_DEPTH(EQ_DEPTH)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cam_in(cam_in),
    .cam_ready(cam_ready), .fill_level(fill_level), .buf_out(buf_out),
    .ev_valid(ev_valid), .ev_word(ev_word), .ev_ready(ev_ready)
);

// *** tb/fbo_cam_model.sv ***
// Camera stream model: sends one eight-beat frame per start request.
// Assumes the supervisor's clock and honours its ready.
`timescale 1ns/1ps
module fbo_cam_model (
    // Clock and handshake
    input wire logic hclk,
    input wire logic cam_ready,
    // Bench control
    input wire logic start,
    input wire logic [15:0] fno,
    // Stream and progress
    output fbo_pkg::fbo_cam_beat_t cam_in,
    output logic busy,
    output logic [3:0] sent
);
    import fbo_pkg::*;
    // ------------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------------
    localparam int BEATS = 8;
    initial begin
        cam_in = '0;
        busy = 1'b0;
        sent = 4'h0;
    end
    // Advance only on a taken beat; idle lines are inverted so stale values never pass
    always @(posedge hclk) begin
        if (busy && cam_ready) begin
            sent <= sent + 4'h1;
            cam_in.sof <= 1'b0;
            // Each line gets one assignment per edge: closing beat or next beat
            if (cam_in.eof) begin
                busy <= 1'b0;
                cam_in.valid <= 1'b0;
                cam_in.eof <= 1'b0;
                cam_in.data <= ~cam_in.data;
                cam_in.frame_no <= ~cam_in.frame_no;
            end else begin
                cam_in.eof <= (sent == 4'(BEATS - 2));
                cam_in.data <= cam_in.data + 32'h1;
            end
        end else if (start && !busy) begin
            busy <= 1'b1;
            sent <= 4'h0;
            cam_in.valid <= 1'b1;
            cam_in.sof <= 1'b1;
            cam_in.eof <= 1'b0;
            cam_in.frame_no <= fno;
        end
    end
endmodule // fbo_cam_model

// *** tb/frame_buffer_overflow_events_tb.sv ***
// Self-checking bench: registers, frame fates, event filter and status.
// Assumes fbo_core with a zero-wait slave and the camera model beside it.
`timescale 1ns/1ps
module frame_buffer_overflow_events_tb;
    import fbo_pkg::*;
    // ------------------------------------------------------------------
    // Signals and design under test
    // ------------------------------------------------------------------
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ev_ready = 1'b1, start = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [6:0] fill = 7'h00;
    logic [15:0] fno = 16'hFFFE;
    logic hreadyout, hresp, cam_ready, ev_valid, busy;
    logic [63:0] ev_word;
    logic [3:0] sent;
    fbo_cam_beat_t cam_in;
    fbo_buf_beat_t buf_out, last_beat;
    logic [63:0] evq[$], expq[$];
    int fails = 0, checks_done = 0, beats = 0, cyc = 0, flt = 2;

    fbo_core #(.EQ_DEPTH(4)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cam_in(cam_in),
        .cam_ready(cam_ready), .fill_level(fill), .buf_out(buf_out),
        .ev_valid(ev_valid), .ev_word(ev_word), .ev_ready(ev_ready)
    );
    fbo_cam_model cam_u (
        .hclk(hclk), .cam_ready(cam_ready), .start(start), .fno(fno),
        .cam_in(cam_in), .busy(busy), .sent(sent)
    );

    // Clock at 40 MHz
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    // Collect events and written beats; cut a hang short
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (ev_valid && ev_ready) evq.push_back(ev_word);
        if (buf_out.valid) begin
            beats <= beats + 1;
            last_beat <= buf_out;
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single AHB-Lite transfer; waits on hready rather than assuming zero wait
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(r, e);
    endtask
    // One frame: 0 good, 1 dropped, 2 truncated, 3 fill raised mid-frame and kept
    task automatic frame(input int fate);
        logic [2:0] fb;
        int b0;
        fb = (fate == 1) ? 3'h2 : (fate == 2) ? 3'h1 : 3'h4;
        // Beat counter has one writer; the frame is judged by its difference
        b0 = beats;
        fill <= (fate == 1) ? 7'h5A : 7'h00;
        repeat (4) @(posedge hclk);
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        @(posedge hclk);
        while (sent == 4'h0) @(posedge hclk);
        if (fate >= 2) fill <= (fate == 2) ? 7'h64 : 7'h5A;
        while (busy) @(posedge hclk);
        repeat (4) @(posedge hclk);
        if (fate != 3) fill <= 7'h00;
        repeat (4) @(posedge hclk);
        if (fate == 1) check(beats - b0, 0);
        else if (fate == 2) check({last_beat.empty, last_beat.truncated}, 2'h3);
        else check(beats - b0, 8);
        // Fill raised after beat 1: fill and state registers let beats 0..3 through, then the close
        if (fate == 2) check(beats - b0, 5);
        if (|(3'(flt + 1) & fb)) expq.push_back({29'h0, fb, 16'h0, fno});
        fno <= fno + 16'h1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd_chk(12'h000, 32'hA0);
        rd_chk(12'h004, 32'hC7);
        rd_chk(12'h008, 32'h64);
        rd_chk(12'h00C, 32'h2);
        rd_chk(12'h014, 32'h0);
        wr(12'h000, 32'hC9);
        rd_chk(12'h000, 32'hC8);
        wr(12'h000, 32'h1);
        rd_chk(12'h000, 32'h1);
        wr(12'h000, 32'hA0);
        wr(12'h00C, 32'h7);
        rd_chk(12'h00C, 32'h2);
        rd_chk(12'h020, 32'h0);
        fill <= 7'h25;
        repeat (3) @(posedge hclk);
        rd_chk(12'h010, 32'h25);
        fill <= 7'h78;
        repeat (3) @(posedge hclk);
        rd_chk(12'h010, 32'h64);
    endtask
    // Every filter setting against a good, a dropped and a truncated frame
    task automatic t_filters();
        for (int f = 0; f < 7; f++) begin
            wr(12'h00C, 32'(f));
            flt = f;
            ev_ready <= (f != 6);
            frame(0);
            ev_ready <= 1'b1;
            frame(1);
            frame(2);
            repeat (8) @(posedge hclk);
            check(evq.size(), expq.size());
            while (evq.size() > 0 && expq.size() > 0)
                check(evq.pop_front() & 64'h0000_FFFF_0000_FFFF, expq.pop_front());
            evq.delete();
            expq.delete();
        end
    endtask
    // Sticky flag, frame-synchronous entry and exit with no hysteresis
    task automatic t_sync();
        rd_chk(12'h014, 32'h1);
        rd_chk(12'h014, 32'h0);
        frame(3);
        rd_chk(12'h014, 32'h4);
        fill <= 7'h50;
        repeat (4) @(posedge hclk);
        rd_chk(12'h014, 32'h4);
        fill <= 7'h4F;
        repeat (4) @(posedge hclk);
        rd_chk(12'h014, 32'h0);
        // Immediate state holds down to the resume threshold, then leaves
        fill <= 7'h64;
        repeat (4) @(posedge hclk);
        fill <= 7'h32;
        repeat (4) @(posedge hclk);
        rd_chk(12'h014, 32'h2);
        fill <= 7'h31;
        repeat (4) @(posedge hclk);
        rd_chk(12'h014, 32'h0);
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_filters();
        t_sync();
        final_report();
    end
endmodule // frame_buffer_overflow_events_tb
